// File: verilog/ecpp_cfg.svh
// offsets, field positions, reset values and constants of the parallel port
`ifndef ECPP_CFG_SVH
`define ECPP_CFG_SVH
`define ECPP_OFS_DATA      11'h000
`define ECPP_OFS_STATUS    11'h001
`define ECPP_OFS_CONTROL   11'h002
`define ECPP_OFS_FIFO      11'h400
`define ECPP_OFS_CFG_B     11'h401
`define ECPP_OFS_EXT_CTRL  11'h402
`define ECPP_CFG_A_VALUE   8'h10
`define ECPP_CTRL_STROBE   0
`define ECPP_CTRL_AUTOFD   1
`define ECPP_CTRL_INIT     2
`define ECPP_CTRL_SELIN    3
`define ECPP_CTRL_ACKIEN   4
`define ECPP_CTRL_DIR      5
`define ECPP_ECR_MODE_LO   5
`define ECPP_ECR_NERRIE    4
`define ECPP_ECR_DMAEN     3
`define ECPP_ECR_SVCINT    2
`define ECPP_ECR_RESET     8'h15
`define ECPP_FIFO_DEPTH    16
`endif

// File: verilog/ecpp_pkg.sv
// types shared by the parallel port files
package ecpp_pkg;
  typedef enum logic [2:0] {
    ECPP_MODE_STD  = 3'h0,
    ECPP_MODE_BIDI = 3'h1,
    ECPP_MODE_FIFO = 3'h2,
    ECPP_MODE_ECP  = 3'h3,
    ECPP_MODE_EPP  = 3'h4,
    ECPP_MODE_RSVD = 3'h5,
    ECPP_MODE_TEST = 3'h6,
    ECPP_MODE_CFG  = 3'h7
  } ecpp_mode_type;
  typedef enum logic [1:0] {
    ECPP_FW_IDLE,
    ECPP_FW_WAIT_BUSY,
    ECPP_FW_STROBE,
    ECPP_FW_RELEASE
  } ecpp_fwd_state_type;
  typedef enum logic [1:0] {
    ECPP_RV_IDLE,
    ECPP_RV_ACK_WAIT,
    ECPP_RV_ACK_DONE
  } ecpp_rev_state_type;
endpackage

// File: verilog/ecpp_buffer.sv
// small valid/ready fifo of flip-flops, parameterised width and depth
`include "ecpp_cfg.svh"
module ecpp_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2,
  parameter int AW    = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [AW:0]      level
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    wr_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH)) || pop;
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign level     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (clk_en && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || (clk_en && flush)) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // ecpp_buffer

// File: verilog/ecpp_core.sv
// parallel port core: register map, forward/reverse handshakes, pins
`include "ecpp_cfg.svh"
module ecpp_core #(
  parameter logic [15:0] BASE_ADDR  = 16'h0378,
  parameter int          FIFO_DEPTH = `ECPP_FIFO_DEPTH,
  parameter logic [2:0]  IRQ_SEL    = 3'h0,
  parameter logic [2:0]  DMA_SEL    = 3'h0,
  parameter bit          EPP_ENABLE = 1'b0
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_aen,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rvalid,
  input  wire logic [7:0]  parallel_data_lines_in,
  output logic      [7:0]  parallel_data_lines_out,
  output logic             parallel_data_lines_oe_n,
  output logic             strobe_n,
  output logic             autofd_n,
  output logic             init_n,
  output logic             select_in_n,
  input  wire logic        ack_n_in,
  input  wire logic        busy_in,
  input  wire logic        perror_in,
  input  wire logic        select_in,
  input  wire logic        fault_n_in,
  output logic             error_irq
);
  localparam int FAW = $clog2(FIFO_DEPTH);

  // three-stage synchronisers on the cable inputs
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] sync3_q;
  logic [4:0] pin_q;
  logic [7:0] pd_s1_q;
  logic [7:0] pd_s2_q;
  logic [7:0] pd_s3_q;
  logic [7:0] pd_q;
  wire  [4:0] raw_in = {fault_n_in, select_in, perror_in, busy_in, ack_n_in};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
      sync3_q <= 5'h1f;
      pin_q   <= 5'h1f;
      pd_s1_q <= 8'h00;
      pd_s2_q <= 8'h00;
      pd_s3_q <= 8'h00;
      pd_q    <= 8'h00;
    end else if (clk_en) begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pd_s1_q <= parallel_data_lines_in;
      pd_s2_q <= pd_s1_q;
      pd_s3_q <= pd_s2_q;
      for (int i = 0; i < 5; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pin_q[i] <= sync3_q[i];
        end
      end
      for (int i = 0; i < 8; i++) begin
        if (pd_s2_q[i] == pd_s3_q[i]) begin
          pd_q[i] <= pd_s3_q[i];
        end
      end
    end
  end

  wire ack_n   = pin_q[0];
  wire busy    = pin_q[1];
  wire perror  = pin_q[2];
  wire sel     = pin_q[3];
  wire fault_n = pin_q[4];

  // registers
  logic [7:0] data_q;
  logic [5:0] ctrl_q;
  logic [7:0] ecr_q;
  logic       fault_irq_q;
  logic       fault_n_d1_q;
  ecpp_pkg::ecpp_mode_type mode;

  assign mode = ecpp_pkg::ecpp_mode_type'(ecr_q[7:`ECPP_ECR_MODE_LO]);

  function automatic logic hit(input logic [15:0] a, input logic [10:0] ofs);
    hit = io_aen ? 1'b0 : (a == BASE_ADDR + {5'h00, ofs});
  endfunction

  wire acc_data = hit(io_addr, `ECPP_OFS_DATA);
  wire acc_stat = hit(io_addr, `ECPP_OFS_STATUS);
  wire acc_ctrl = hit(io_addr, `ECPP_OFS_CONTROL);
  wire acc_fifo = hit(io_addr, `ECPP_OFS_FIFO);
  wire acc_cfgb = hit(io_addr, `ECPP_OFS_CFG_B);
  wire acc_ecr  = hit(io_addr, `ECPP_OFS_EXT_CTRL);

  wire is_ecp     = mode == ecpp_pkg::ECPP_MODE_ECP;
  wire fixed_out  = mode == ecpp_pkg::ECPP_MODE_STD ||
                    mode == ecpp_pkg::ECPP_MODE_FIFO;
  wire dir_rev    = ctrl_q[`ECPP_CTRL_DIR] && !fixed_out;
  wire latch_mode = mode == ecpp_pkg::ECPP_MODE_STD ||
                    mode == ecpp_pkg::ECPP_MODE_BIDI ||
                    (mode == ecpp_pkg::ECPP_MODE_EPP && EPP_ENABLE);

  // shared fifo: tag bit 8 marks address/rle bytes going out, and holds busy on bytes coming in
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [8:0] fifo_in_data;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [8:0] fifo_out_data;
  logic [FAW:0] fifo_level;
  logic       rev_push;
  logic       fw_pop;
  logic [7:0] last_rd_q;

  wire host_fifo_wr = io_wr && acc_fifo &&
                      (mode == ecpp_pkg::ECPP_MODE_FIFO ||
                       mode == ecpp_pkg::ECPP_MODE_TEST ||
                       (is_ecp && !dir_rev));
  wire host_afifo_wr = io_wr && acc_data && is_ecp && !dir_rev;
  wire host_fifo_rd  = io_rd && acc_fifo &&
                       (mode == ecpp_pkg::ECPP_MODE_TEST ||
                        (is_ecp && dir_rev));

  always_comb begin
    fifo_in_valid = host_fifo_wr || host_afifo_wr || rev_push;
    fifo_in_data  = rev_push ? {busy, pd_q}
                             : {host_afifo_wr, io_wdata};
    fifo_out_ready = host_fifo_rd || fw_pop;
  end

  ecpp_buffer #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FAW)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .flush     (acc_ecr && io_wr),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  wire fifo_full  = !fifo_in_ready || fifo_level == (FAW+1)'(FIFO_DEPTH);
  wire fifo_empty = !fifo_out_valid;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      data_q <= 8'h00;
      ctrl_q <= 6'h00;
      ecr_q  <= `ECPP_ECR_RESET;
    end else if (clk_en && io_wr) begin
      if (acc_data && latch_mode) begin
        data_q <= io_wdata;
      end
      if (acc_ctrl) begin
        ctrl_q <= io_wdata[5:0];
      end
      if (acc_ecr) begin
        ecr_q <= {io_wdata[7:2], ecr_q[1:0]};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      last_rd_q <= 8'h00;
    end else if (clk_en && host_fifo_rd && fifo_out_valid) begin
      last_rd_q <= fifo_out_data[7:0];
    end
  end

  // read mux, answered one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      io_rdata  <= 8'h00;
      io_rvalid <= 1'b0;
    end else if (clk_en) begin
      io_rvalid <= io_rd && !io_aen;
      io_rdata  <= 8'h00;
      if (io_rd) begin
        if (acc_data && !is_ecp) begin
          io_rdata <= pd_q;
        end
        if (acc_stat) begin
          io_rdata <= {!busy, ack_n, perror, sel, fault_n, 3'h0};
        end
        if (acc_ctrl) begin
          io_rdata <= {2'h0, ctrl_q};
        end
        if (acc_fifo) begin
          if (mode == ecpp_pkg::ECPP_MODE_CFG) begin
            io_rdata <= `ECPP_CFG_A_VALUE;
          end else if (host_fifo_rd) begin
            io_rdata <= fifo_out_valid ? fifo_out_data[7:0] : last_rd_q;
          end
        end
        if (acc_cfgb && mode == ecpp_pkg::ECPP_MODE_CFG) begin
          io_rdata <= {1'b0, error_irq, IRQ_SEL, DMA_SEL};
        end
        if (acc_ecr) begin
          io_rdata <= {ecr_q[7:2], fifo_full, fifo_empty};
        end
      end
    end
  end

  // fault interrupt: falling edge, or unmask while asserted
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fault_n_d1_q <= 1'b1;
      fault_irq_q  <= 1'b0;
    end else if (clk_en) begin
      fault_n_d1_q <= fault_n;
      if (is_ecp && ((!ecr_q[`ECPP_ECR_NERRIE] && fault_n_d1_q && !fault_n) ||
          (acc_ecr && io_wr && ecr_q[`ECPP_ECR_NERRIE] && !fault_n &&
           !io_wdata[`ECPP_ECR_NERRIE]))) begin
        fault_irq_q <= 1'b1;
      end else begin
        fault_irq_q <= 1'b0;
      end
    end
  end
  assign error_irq = fault_irq_q;

  // forward engine: fifo mode and ecp forward
  ecpp_pkg::ecpp_fwd_state_type fw_q;
  logic [7:0] fw_byte_q;
  logic       fw_tag_q;
  logic       rev_req_q;
  wire fw_run = (mode == ecpp_pkg::ECPP_MODE_FIFO) || (is_ecp && !dir_rev);

  assign fw_pop = fw_q == ecpp_pkg::ECPP_FW_IDLE && fw_run && fifo_out_valid;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fw_q      <= ecpp_pkg::ECPP_FW_IDLE;
      fw_byte_q <= 8'h00;
      fw_tag_q  <= 1'b0;
    end else if (clk_en) begin
      case (fw_q)
        ecpp_pkg::ECPP_FW_IDLE: begin
          if (fw_pop) begin
            fw_byte_q <= fifo_out_data[7:0];
            fw_tag_q  <= fifo_out_data[8];
            fw_q      <= ecpp_pkg::ECPP_FW_WAIT_BUSY;
          end
        end
        ecpp_pkg::ECPP_FW_WAIT_BUSY: begin
          if (!busy) begin
            fw_q <= ecpp_pkg::ECPP_FW_STROBE;
          end
        end
        ecpp_pkg::ECPP_FW_STROBE: begin
          if (busy) begin
            fw_q <= ecpp_pkg::ECPP_FW_RELEASE;
          end
        end
        ecpp_pkg::ECPP_FW_RELEASE: begin
          if (!busy || !fw_run) begin
            fw_q <= ecpp_pkg::ECPP_FW_IDLE;
          end
        end
        default: fw_q <= ecpp_pkg::ECPP_FW_IDLE;
      endcase
    end
  end

  // reverse engine: host ack requests, nack marks data
  ecpp_pkg::ecpp_rev_state_type rv_q;
  wire rev_ok = is_ecp && dir_rev && !perror;

  assign rev_push = rv_q == ecpp_pkg::ECPP_RV_ACK_WAIT && !ack_n &&
                    fifo_in_ready && !host_fifo_wr && !host_afifo_wr;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rv_q <= ecpp_pkg::ECPP_RV_IDLE;
    end else if (clk_en) begin
      case (rv_q)
        ecpp_pkg::ECPP_RV_IDLE: begin
          if (rev_ok && fifo_in_ready) begin
            rv_q <= ecpp_pkg::ECPP_RV_ACK_WAIT;
          end
        end
        ecpp_pkg::ECPP_RV_ACK_WAIT: begin
          if (rev_push) begin
            rv_q <= ecpp_pkg::ECPP_RV_ACK_DONE;
          end else if (!rev_ok) begin
            rv_q <= ecpp_pkg::ECPP_RV_IDLE;
          end
        end
        ecpp_pkg::ECPP_RV_ACK_DONE: begin
          if (ack_n) begin
            rv_q <= ecpp_pkg::ECPP_RV_IDLE;
          end
        end
        default: rv_q <= ecpp_pkg::ECPP_RV_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rev_req_q <= 1'b0;
    end else if (clk_en) begin
      rev_req_q <= is_ecp && dir_rev;
    end
  end

  // pin drivers
  always_comb begin
    strobe_n    = !ctrl_q[`ECPP_CTRL_STROBE];
    autofd_n    = !ctrl_q[`ECPP_CTRL_AUTOFD];
    init_n      = ctrl_q[`ECPP_CTRL_INIT];
    select_in_n = !ctrl_q[`ECPP_CTRL_SELIN];
    parallel_data_lines_out  = data_q;
    parallel_data_lines_oe_n = dir_rev;
    if (mode == ecpp_pkg::ECPP_MODE_FIFO) begin
      strobe_n = fw_q != ecpp_pkg::ECPP_FW_STROBE;
      parallel_data_lines_out = fw_byte_q;
    end else if (mode == ecpp_pkg::ECPP_MODE_TEST) begin
      parallel_data_lines_out = fifo_out_data[7:0];
    end else if (is_ecp) begin
      select_in_n = 1'b1;
      init_n      = !rev_req_q;
      if (dir_rev) begin
        strobe_n = 1'b1;
        autofd_n = rv_q != ecpp_pkg::ECPP_RV_ACK_WAIT;
        parallel_data_lines_oe_n = 1'b1;
      end else begin
        strobe_n = fw_q != ecpp_pkg::ECPP_FW_STROBE;
        autofd_n = !fw_tag_q;
        parallel_data_lines_out  = fw_byte_q;
        parallel_data_lines_oe_n = !perror;
      end
    end
  end
endmodule // ecpp_core

// File: sim/ecpp_core_sva.sv
// concurrent checks on the parallel port core's pins and register bus
module ecpp_core_sva #(
  parameter logic [15:0] BASE_ADDR = 16'h0378
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [15:0] io_addr,
  input wire logic        io_aen,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic [7:0]  parallel_data_lines_out,
  input wire logic        parallel_data_lines_oe_n,
  input wire logic        strobe_n,
  input wire logic        init_n,
  input wire logic        select_in_n,
  input wire logic        busy_in,
  input wire logic        error_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0]  mode_q;
  logic        nerr_q;
  logic        dir_q;
  logic [3:0]  lo_q;
  logic [15:0] ofs;
  assign ofs = io_addr - BASE_ADDR;
  // shadow of mode and direction as written by the host
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_q <= 3'h0;
      nerr_q <= 1'b1;
      dir_q  <= 1'b0;
    end else if (io_wr && !io_aen && ofs == 16'h0402) begin
      mode_q <= io_wdata[7:5];
      nerr_q <= io_wdata[4];
    end else if (io_wr && !io_aen && ofs == 16'h0002) begin
      dir_q <= io_wdata[5];
    end
  end
  // cycles busy has been low, saturating
  always_ff @(posedge core_clk) begin
    if (!rst_n || busy_in) begin
      lo_q <= 4'h0;
    end else if (lo_q != 4'hf) begin
      lo_q <= lo_q + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_stat_rd;
    io_rd && !io_aen && ofs == 16'h0001;
  endsequence
  sequence s_data_wr;
    io_wr && !io_aen && ofs == 16'h0000 && mode_q == 3'h0;
  endsequence
  a_aen_ignored: assert property (io_rd && io_aen |=> !io_rvalid)
    else $error("read answered with aen high");
  a_status_zero: assert property (s_stat_rd |=> io_rdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_data_drive: assert property (s_data_wr |=>
    parallel_data_lines_out == $past(io_wdata))
    else $error("data byte not on pins");
  a_std_drives: assert property (
    mode_q == 3'h0 || mode_q == 3'h2 |-> !parallel_data_lines_oe_n)
    else $error("port not driving in mode 0 or 2");
  a_ecp_selin: assert property (mode_q == 3'h3 |-> select_in_n)
    else $error("select-in asserted in ecp mode");
  a_init_dir: assert property (
    mode_q == 3'h3 && $past(mode_q) == 3'h3 |-> init_n == !$past(dir_q))
    else $error("init pin disagrees with direction");
  a_strobe_ready: assert property (
    mode_q == 3'h3 && $fell(strobe_n) |-> lo_q > 4'h1)
    else $error("strobe while peripheral busy");
  a_irq_gated: assert property (error_irq |-> mode_q == 3'h3 && !nerr_q)
    else $error("error interrupt while disabled");
endmodule // ecpp_core_sva

bind ecpp_core ecpp_core_sva #(.BASE_ADDR(BASE_ADDR)) u_sva (
  .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_aen(io_aen),
  .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .io_rvalid(io_rvalid), .parallel_data_lines_out(parallel_data_lines_out),
  .parallel_data_lines_oe_n(parallel_data_lines_oe_n),
  .strobe_n(strobe_n), .init_n(init_n), .select_in_n(select_in_n),
  .busy_in(busy_in), .error_irq(error_irq)
);

// File: sim/ecpp_periph_model.sv
// printer-side model: forward sink, reverse source, fault hint
module ecpp_periph_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       hold,
  input  wire logic       fault_req,
  input  wire logic [7:0] host_data,
  input  wire logic       host_oe_n,
  input  wire logic       strobe_n,
  input  wire logic       autofd_n,
  input  wire logic       init_n,
  input  wire logic       select_in_n,
  output logic      [7:0] pins,
  output logic            ack_n,
  output logic            busy,
  output logic            perror,
  output logic            fault_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got [0:31];
  logic [7:0] last;
  logic       drive;
  int         n_got;
  int         n_rev;
  always_ff @(posedge core_clk) begin
    last    <= pins;
    perror  <= init_n;
    fault_n <= !(fault_req && init_n);
    if (!rst_n) begin
      busy  <= 1'b0;
      ack_n <= 1'b1;
      n_got <= 0;
      n_rev <= 0;
    end else if (init_n) begin
      ack_n <= 1'b1;
      if (!strobe_n && !busy) begin
        got[n_got] <= {!autofd_n, host_data};
        n_got      <= n_got + 1;
        busy       <= 1'b1;
      end else if (strobe_n) begin
        busy <= hold;
      end
    end else begin
      busy <= 1'b1;
      if (drive && ack_n && n_rev < 4) begin
        ack_n <= 1'b0;
      end else if (autofd_n && !ack_n) begin
        ack_n <= 1'b1;
        n_rev <= n_rev + 1;
      end
    end
  end
  assign drive = !init_n && !perror && !autofd_n && select_in_n;
  // released lines show a changing pattern, not the last value
  assign pins = !host_oe_n ? host_data : drive ? 8'ha0 + n_rev[7:0] : ~last;
endmodule // ecpp_periph_model

// File: sim/test_ecp_parallel_port_core.sv
// self-checking bench for the parallel port core
module test_ecp_parallel_port_core;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] BA = 16'h0378;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        io_aen = 1'b0;
  logic        io_rd = 1'b0;
  logic        io_wr = 1'b0;
  logic        hold = 1'b0;
  logic        fault_req = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0]  io_wdata = 8'h00;
  logic [7:0]  io_rdata, pd_out, pins, d;
  logic [8:0]  exp_q [0:16];
  logic        io_rvalid, oe_n, stb_n, afd_n, ini_n, sel_n;
  logic        ack_n, busy, perr, flt_n, irq;
  logic [31:0] seed = 32'd65758;
  int          mismatches = 0;
  int          num_checks = 0;
  int          irqs = 0;
  ecpp_core uut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
    .io_addr(io_addr), .io_aen(io_aen), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .parallel_data_lines_in(pins), .parallel_data_lines_out(pd_out),
    .parallel_data_lines_oe_n(oe_n), .strobe_n(stb_n), .autofd_n(afd_n),
    .init_n(ini_n), .select_in_n(sel_n), .ack_n_in(ack_n),
    .busy_in(busy), .perror_in(perr), .select_in(1'b1),
    .fault_n_in(flt_n), .error_irq(irq)
  );
  ecpp_periph_model u_per (
    .core_clk(core_clk), .rst_n(rst_n), .hold(hold),
    .fault_req(fault_req), .host_data(pd_out), .host_oe_n(oe_n),
    .strobe_n(stb_n), .autofd_n(afd_n), .init_n(ini_n),
    .select_in_n(sel_n), .pins(pins), .ack_n(ack_n), .busy(busy),
    .perror(perr), .fault_n(flt_n)
  );
  always #10 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    if (irq === 1'b1) irqs++;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [15:0] w, input logic [8:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %h expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] o, input logic [7:0] v, input logic a);
    @(negedge core_clk);
    io_addr = BA + o;
    io_wdata = v;
    io_aen = a;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
    io_aen = 1'b0;
  endtask
  // with aen high nothing answers and read data stays zero
  task automatic rd(input logic [15:0] o, input logic [7:0] e, input logic a);
    @(negedge core_clk);
    io_addr = BA + o;
    io_aen = a;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    io_aen = 1'b0;
    chk(o, {!a, a ? 8'h00 : e}, {io_rvalid, io_rdata});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    rd(16'h0402, 8'h15, 1'b0);
    rd(16'h0001, 8'h00, 1'b1);
    wr(16'h0002, 8'h04, 1'b0);
    for (int m = 0; m < 8; m++) begin
      if (m != 4) begin
        wr(16'h0402, {m[2:0], 5'h14}, 1'b0);
        rd(16'h0402, {m[2:0], 5'h15}, 1'b0);
      end
      if (m < 2 || m == 7) rd(16'h0400, {3'h0, m == 7, 4'h0}, 1'b0);
      if (m == 7) rd(16'h0401, 8'h00, 1'b0);
      if (m == 5) begin
        chk(16'h0002, 9'h00f, {5'h00, stb_n, afd_n, ini_n, sel_n});
      end
    end
    wr(16'h0402, 8'h14, 1'b0);
    repeat (6) begin
      d = rnd();
      wr(16'h0000, d, 1'b0);
      chk(16'h0000, {1'b0, d}, {oe_n, pd_out});
      repeat (4) @(negedge core_clk);
      rd(16'h0000, d, 1'b0);
      wr(16'h0000, ~d, 1'b1);
      rd(16'h0000, d, 1'b0);
    end
    wr(16'h0002, 8'h24, 1'b0);
    chk(16'h0002, 9'h000, {oe_n, 8'h00});
    repeat (8) @(negedge core_clk);
    rd(16'h0001, 8'hf8, 1'b0);
    wr(16'h0002, 8'h04, 1'b0);
    hold = 1'b1;
    wr(16'h0402, 8'h74, 1'b0);
    for (int i = 0; i < 6; i++) begin
      exp_q[i] = {i == 0, rnd()};
      wr(i == 0 ? 16'h0000 : 16'h0400, exp_q[i][7:0], 1'b0);
    end
    hold = 1'b0;
    for (int k = 0; k < 3000 && u_per.n_got < 6; k++) @(negedge core_clk);
    for (int i = 0; i < 6; i++) begin
      chk(16'h0400, exp_q[i], u_per.got[i]);
    end
    wr(16'h0002, 8'h24, 1'b0);
    for (int k = 0; k < 3000 && u_per.n_rev < 4; k++) @(negedge core_clk);
    repeat (8) @(negedge core_clk);
    chk(16'h0002, 9'h100, {oe_n, 8'h00});
    for (int i = 0; i < 4; i++) rd(16'h0400, 8'ha0 + i[7:0], 1'b0);
    wr(16'h0002, 8'h04, 1'b0);
    wr(16'h0402, 8'h64, 1'b0);
    fault_req = 1'b1;
    for (int k = 0; k < 100 && irqs == 0; k++) @(negedge core_clk);
    repeat (8) @(negedge core_clk);
    chk(16'h0402, 9'h001, {1'b0, irqs[7:0]});
    fault_req = 1'b0;
    repeat (8) @(negedge core_clk);
    wr(16'h0402, 8'h74, 1'b0);
    fault_req = 1'b1;
    repeat (20) @(negedge core_clk);
    chk(16'h0402, 9'h001, {1'b0, irqs[7:0]});
    wr(16'h0402, 8'h64, 1'b0);
    repeat (8) @(negedge core_clk);
    chk(16'h0402, 9'h002, {1'b0, irqs[7:0]});
    fault_req = 1'b0;
    wr(16'h0402, 8'hd4, 1'b0);
    for (int i = 0; i < 17; i++) begin
      exp_q[i] = {1'b0, rnd()};
      wr(16'h0400, exp_q[i][7:0], 1'b0);
    end
    rd(16'h0402, 8'hd6, 1'b0);
    for (int i = 0; i < 17; i++) begin
      rd(16'h0400, exp_q[i - i / 16][7:0], 1'b0);
    end
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    chk(16'h0000, 9'h000, {oe_n, pd_out});
    report_and_stop();
  end
endmodule // test_ecp_parallel_port_core
